// ===== reset_wake_pkg.sv
// Purpose : shared constants and types for the reset, sleep and boot control block
// Assumes : 16-bit control words and 16-bit register addresses
// Notes   : offsets, field positions, reset values and timing counts live here only
package reset_wake_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RESET_ID    = 16'h0000;
    localparam logic [15:0] ADDR_MISC_PAD    = 16'h0C20;
    localparam logic [15:0] ADDR_PIN_FUNC    = 16'h0C30;
    localparam logic [15:0] ADDR_RAW_STATUS5 = 16'h0D23;
    localparam logic [15:0] ADDR_WSEQ_BASE   = 16'h3000;
    localparam int          WSEQ_DEPTH       = 32;
    localparam int          WSEQ_IDX_W       = 5;
    localparam logic [15:0] ADDR_WSEQ_END    = ADDR_WSEQ_BASE + 16'(WSEQ_DEPTH);

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          RESET_PIN_PULLDOWN_EN_BIT     = 0;
    localparam int          RESET_PIN_PULLUP_EN_BIT     = 1;
    localparam int          CORE_EN_PU_BIT   = 14;
    localparam int          CORE_EN_PD_BIT   = 15;
    localparam int          BOOT_STATUS_BIT  = 8;
    localparam logic [15:0] MISC_PAD_RESET   = 16'h8002;
    localparam logic [15:0] MISC_PAD_AON     = 16'hC003;
    localparam logic [15:0] MISC_PAD_USED    = 16'hC003;
    // gpio inputs with pull-down, mic pins analog, addr and regulator enable pulled down
    localparam logic [15:0] PIN_FUNC_RESET   = 16'hC3E0;
    // general_pin_5 direction and pull, regulator enable pull: kept through sleep
    localparam logic [15:0] PIN_FUNC_AON     = 16'h8210;
    // arbitrary neutral identity value
    localparam logic [15:0] DEVICE_ID_VALUE  = 16'h1234;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          BOOT_TIME_NS     = 1000;
    localparam int          BOOT_CYCLES      = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          BOOT_CNT_W       = 12;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       core_en_pd;
        logic       addr_pd;
        logic [3:0] dmic_sel;
        logic [4:0] gpio_pd;
        logic [4:0] gpio_dir;
    } pad_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        BOOT_HOLD,
        BOOT_RUN,
        BOOT_DONE
    } boot_state_t;

endpackage

// ===== wseq_store.sv
// Purpose : write sequencer memory that only power-on reset clears
// Assumes : one write port, one combinational read port
// Notes   : the caller gates writes; this store never sees the soft or pin reset
`timescale 1ns/1ps
`default_nettype none
module wseq_store #(
    parameter int DEPTH = reset_wake_pkg::WSEQ_DEPTH,
    parameter int IDX_W = reset_wake_pkg::WSEQ_IDX_W
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wr_in,
    input  wire logic [IDX_W-1:0] wr_idx_in,
    input  wire logic [15:0]      wdata_in,
    input  wire logic [IDX_W-1:0] rd_idx_in,
    output logic      [15:0]      rdata_out
);

    logic [15:0] mem_reg [DEPTH];

    // ------------------------------------------------------------
    // storage, cleared by power-on reset alone
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= 16'h0000;
            end
        end
        else if (wr_in)
        begin
            mem_reg[wr_idx_in] <= wdata_in;
        end
    end

    assign rdata_out = mem_reg[rd_idx_in];

endmodule // wseq_store
`default_nettype wire

// ===== reset_wake_boot_control.sv
// Purpose : reset, sleep, wake-up and boot control with reset-default pad state
// Assumes : rst_n_in is power-on reset; supply flags and reset pin are asynchronous pins
// Notes   : host requests come from the control interface decoder on the same clock
//
// Operation
// - sleep when analog, io present, core low
// - sleep holds core registers, always-on ones survive
// - resets restore power-on pin defaults
// - wake keeps always-on pin configuration
// - boot or wake sequence may override defaults
// - gpio, addr, regulator enable pulled-down inputs
// - reset pin input with pull-up
// - shared mic pins default to analog
// - low reset pin causes hardware reset
// - hardware reset keeps sequencer memory
// - pull-up bit1 default 1, pull-down bit0 0
// - both pulls set gives bus keeper
// - any host write to address zero after boot resets
// - software reset keeps sequencer memory
// - wake acts as software reset, always-on kept
// - sequencer memory cleared only by power-on
// - boot sequence runs after every reset
// - boot flag low in reset, set after boot
// - boot flag feeds interrupt and gpio
// - boot flag is raw status bit 8
// - address zero reads identity code
`timescale 1ns/1ps
`default_nettype none
module reset_wake_boot_control #(
    parameter int BOOT_CYCLES = reset_wake_pkg::BOOT_CYCLES
) (
    input  wire logic                      mclk_in,
    input  wire logic                      rst_n_in,
    input  wire reset_wake_pkg::reg_req_t  host_req_in,
    input  wire reset_wake_pkg::reg_req_t  seq_req_in,
    output logic [15:0]                    reg_rdata_out,
    output logic                           reg_ack_out,
    output logic                           reg_err_out,
    input  wire logic                      reset_pin_n_in,
    input  wire logic                      analog_supply_ok_in,
    input  wire logic                      io_supply_one_ok_in,
    input  wire logic                      core_supply_ok_in,
    output logic                           reset_pin_pullup_en_out,
    output logic                           reset_pin_pulldown_en_out,
    output logic                           reset_keeper_oe_out,
    output logic                           reset_keeper_level_out,
    output logic                           core_regulator_enable_pin_pu_out,
    output reset_wake_pkg::pad_cfg_t       pad_cfg_out,
    output logic [5:0]                     fixed_out_oe_out,
    output logic                           sleep_out,
    output logic                           boot_complete_flag_out,
    output logic                           boot_event_out,
    output logic                           boot_gpio_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [3:0]                  sync1_reg;
    logic [3:0]                  sync2_reg;
    logic                        pin_lvl;
    logic                        hw_rst;
    logic                        sleep;
    logic                        soft_rst_reg;
    logic                        aon_rst;
    logic                        core_rst;
    reset_wake_pkg::boot_state_t boot_state_reg;
    logic [reset_wake_pkg::BOOT_CNT_W-1:0] boot_cnt_reg;
    logic                        boot_done;
    logic                        boot_done_d_reg;
    logic                        host_wr_ok;
    logic                        seq_wr_ok;
    reset_wake_pkg::reg_req_t    wr_src;
    logic                        wr_en;
    logic [15:0]                 misc_pad_reg;
    logic [15:0]                 pin_func_reg;
    logic [15:0]                 seq_rdata;
    logic [15:0]                 rdata_next;
    logic                        mapped;
    logic [15:0]                 rdata_reg;
    logic                        ack_reg;
    logic                        err_reg;

    function automatic logic is_seq(input logic [15:0] a);
        is_seq = (a >= reset_wake_pkg::ADDR_WSEQ_BASE) && (a < reset_wake_pkg::ADDR_WSEQ_END);
    endfunction

    function automatic logic [15:0] keep_aon(input logic [15:0] cur, input logic [15:0] def,
                                             input logic [15:0] mask);
        keep_aon = (cur & mask) | (def & ~mask);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            sync1_reg <= 4'h1;
            sync2_reg <= 4'h1;
        end
        else
        begin
            sync1_reg <= {core_supply_ok_in, io_supply_one_ok_in, analog_supply_ok_in, reset_pin_n_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign pin_lvl  = sync2_reg[0];
    assign hw_rst   = !pin_lvl;
    assign sleep    = sync2_reg[1] && sync2_reg[2] && !sync2_reg[3];
    assign aon_rst  = hw_rst || soft_rst_reg;
    assign core_rst = aon_rst || sleep;

    // ------------------------------------------------------------
    // software reset strobe
    // ------------------------------------------------------------
    assign host_wr_ok = host_req_in.wr && boot_done && !core_rst;
    assign seq_wr_ok  = seq_req_in.wr && (boot_state_reg == reset_wake_pkg::BOOT_RUN) && !core_rst;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            soft_rst_reg <= 1'b0;
        end
        else
        begin
            soft_rst_reg <= host_wr_ok && (host_req_in.addr == reset_wake_pkg::ADDR_RESET_ID);
        end
    end

    // ------------------------------------------------------------
    // boot sequence
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || core_rst)
        begin
            boot_state_reg <= reset_wake_pkg::BOOT_HOLD;
            boot_cnt_reg   <= '0;
        end
        else
        begin
            unique case (boot_state_reg)
                reset_wake_pkg::BOOT_HOLD:
                begin
                    boot_state_reg <= reset_wake_pkg::BOOT_RUN;
                    boot_cnt_reg   <= '0;
                end
                reset_wake_pkg::BOOT_RUN:
                begin
                    if (boot_cnt_reg == reset_wake_pkg::BOOT_CNT_W'(BOOT_CYCLES - 1))
                    begin
                        boot_state_reg <= reset_wake_pkg::BOOT_DONE;
                    end
                    else
                    begin
                        boot_cnt_reg <= boot_cnt_reg + 1'b1;
                    end
                end
                reset_wake_pkg::BOOT_DONE:
                begin
                    boot_state_reg <= reset_wake_pkg::BOOT_DONE;
                end
            endcase
        end
    end

    assign boot_done = (boot_state_reg == reset_wake_pkg::BOOT_DONE);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            boot_done_d_reg <= 1'b0;
        end
        else
        begin
            boot_done_d_reg <= boot_done;
        end
    end

    // flag drops with the internal reset itself, not one edge later when the state clears
    assign boot_complete_flag_out = boot_done && !core_rst;
    assign boot_event_out         = boot_done && !boot_done_d_reg;
    assign boot_gpio_out          = boot_complete_flag_out;

    // ------------------------------------------------------------
    // pad control registers
    // ------------------------------------------------------------
    assign wr_src = seq_wr_ok ? seq_req_in : host_req_in;
    assign wr_en  = seq_wr_ok || host_wr_ok;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || aon_rst)
        begin
            misc_pad_reg <= reset_wake_pkg::MISC_PAD_RESET;
        end
        else if (wr_en && (wr_src.addr == reset_wake_pkg::ADDR_MISC_PAD))
        begin
            misc_pad_reg <= wr_src.wdata & reset_wake_pkg::MISC_PAD_USED;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || aon_rst)
        begin
            pin_func_reg <= reset_wake_pkg::PIN_FUNC_RESET;
        end
        else if (sleep)
        begin
            // wake restarts from defaults except the always-on pins
            pin_func_reg <= keep_aon(pin_func_reg, reset_wake_pkg::PIN_FUNC_RESET,
                                     reset_wake_pkg::PIN_FUNC_AON);
        end
        else if (wr_en && (wr_src.addr == reset_wake_pkg::ADDR_PIN_FUNC))
        begin
            pin_func_reg <= wr_src.wdata;
        end
    end

    assign pad_cfg_out                      = reset_wake_pkg::pad_cfg_t'(pin_func_reg);
    assign reset_pin_pullup_en_out          = misc_pad_reg[reset_wake_pkg::RESET_PIN_PULLUP_EN_BIT];
    assign reset_pin_pulldown_en_out        = misc_pad_reg[reset_wake_pkg::RESET_PIN_PULLDOWN_EN_BIT];
    assign core_regulator_enable_pin_pu_out = misc_pad_reg[reset_wake_pkg::CORE_EN_PU_BIT];
    // both pulls on: hold the last sampled level on the pin
    assign reset_keeper_oe_out    = reset_pin_pullup_en_out && reset_pin_pulldown_en_out;
    assign reset_keeper_level_out = pin_lvl;
    // transmit data x3, speaker clock, speaker data, interrupt: outputs from reset
    assign fixed_out_oe_out       = 6'h3F;
    assign sleep_out              = sleep;

    // ------------------------------------------------------------
    // sequencer memory, untouched by pin, soft reset and sleep
    // ------------------------------------------------------------
    wseq_store #(
        .DEPTH (reset_wake_pkg::WSEQ_DEPTH),
        .IDX_W (reset_wake_pkg::WSEQ_IDX_W)
    ) u_wseq_store (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .wr_in     (host_wr_ok && is_seq(host_req_in.addr)),
        .wr_idx_in (host_req_in.addr[reset_wake_pkg::WSEQ_IDX_W-1:0]),
        .wdata_in  (host_req_in.wdata),
        .rd_idx_in (host_req_in.addr[reset_wake_pkg::WSEQ_IDX_W-1:0]),
        .rdata_out (seq_rdata)
    );

    // ------------------------------------------------------------
    // register read and answer
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_next = 16'h0000;
        mapped     = 1'b1;
        if (host_req_in.addr == reset_wake_pkg::ADDR_RESET_ID)
        begin
            rdata_next = reset_wake_pkg::DEVICE_ID_VALUE;
        end
        else if (host_req_in.addr == reset_wake_pkg::ADDR_MISC_PAD)
        begin
            rdata_next = misc_pad_reg;
        end
        else if (host_req_in.addr == reset_wake_pkg::ADDR_PIN_FUNC)
        begin
            rdata_next = pin_func_reg;
        end
        else if (host_req_in.addr == reset_wake_pkg::ADDR_RAW_STATUS5)
        begin
            rdata_next[reset_wake_pkg::BOOT_STATUS_BIT] = boot_complete_flag_out;
        end
        else if (is_seq(host_req_in.addr))
        begin
            rdata_next = seq_rdata;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            ack_reg   <= host_req_in.wr || host_req_in.rd;
            // status register is read-only; early writes refused
            err_reg   <= (host_req_in.wr && (!host_wr_ok ||
                          host_req_in.addr == reset_wake_pkg::ADDR_RAW_STATUS5)) ||
                         ((host_req_in.wr || host_req_in.rd) && !mapped);
            rdata_reg <= host_req_in.rd ? rdata_next : 16'h0000;
        end
    end

    assign reg_ack_out   = ack_reg;
    assign reg_err_out   = err_reg;
    assign reg_rdata_out = rdata_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_sleep_entry;
        (analog_supply_ok_in && io_supply_one_ok_in && !core_supply_ok_in)[*3] |-> sleep_out;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_flag_low_in_sleep;
        sleep_out |-> !boot_complete_flag_out;
    endproperty
    a_flag_low_in_sleep: assert property (p_flag_low_in_sleep) else $error("boot flag set in sleep");

    property p_boot_length;
        $rose(boot_complete_flag_out) |-> $past(boot_cnt_reg) == reset_wake_pkg::BOOT_CNT_W'(BOOT_CYCLES - 1);
    endproperty
    a_boot_length: assert property (p_boot_length) else $error("boot length wrong");

    property p_refuse_early;
        (host_req_in.wr && !boot_complete_flag_out) |=> reg_err_out && reg_ack_out;
    endproperty
    a_refuse_early: assert property (p_refuse_early) else $error("early write not refused");

    property p_soft_reset;
        (host_req_in.wr && host_req_in.addr == 16'h0000 && boot_complete_flag_out && !core_rst)
            |=> ##1 !boot_complete_flag_out;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

    property p_pin_reset;
        (!reset_pin_n_in)[*3] |-> !boot_complete_flag_out;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");

    property p_keeper_level;
        reset_keeper_oe_out |-> reset_keeper_level_out == $past(reset_pin_n_in, 2);
    endproperty
    a_keeper_level: assert property (p_keeper_level) else $error("keeper level wrong");

    property p_aon_kept;
        (sleep_out && !aon_rst) |=> ((pad_cfg_out & reset_wake_pkg::PIN_FUNC_AON) ==
                                     ($past(pad_cfg_out) & reset_wake_pkg::PIN_FUNC_AON));
    endproperty
    a_aon_kept: assert property (p_aon_kept) else $error("always-on pins changed");

    property p_defaults;
        core_rst |=> ((pad_cfg_out & ~reset_wake_pkg::PIN_FUNC_AON) ==
                      (reset_wake_pkg::PIN_FUNC_RESET & ~reset_wake_pkg::PIN_FUNC_AON));
    endproperty
    a_defaults: assert property (p_defaults) else $error("pin defaults not restored");

    property p_pull_defaults;
        aon_rst |=> reset_pin_pullup_en_out && !reset_pin_pulldown_en_out;
    endproperty
    a_pull_defaults: assert property (p_pull_defaults) else $error("pull defaults wrong");

    c_boot_done:  cover property ($rose(boot_complete_flag_out));
    c_sleep_wake: cover property ($fell(sleep_out) ##[1:200] boot_complete_flag_out);
    c_soft_reset: cover property ($rose(soft_rst_reg));
    c_keeper:     cover property (reset_keeper_oe_out);

endmodule // reset_wake_boot_control
`default_nettype wire

// ===== host_model.sv
// Purpose: host processor model on the register request port
// Assumes: one request at a time, answer registered on the taking edge and read 1 ns after it
// Notes  : writes wait for boot completion unless a refusal is being provoked
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                 mclk_in,
    input  wire logic                 flag_in,
    input  wire logic                 ack_in,
    input  wire logic                 err_in,
    input  wire logic [15:0]          rdata_in,
    output var reset_wake_pkg::reg_req_t req_out
);
    initial req_out = '0;

    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wd,
                          input logic early, output logic [15:0] rd, output logic er);
        int n;
        n = 0;
        while (wr && !early && flag_in !== 1'b1 && n < 2000)
        begin
            @(posedge mclk_in);
            n++;
        end
        @(posedge mclk_in);
        #1;
        req_out = '{wr: wr, rd: !wr, addr: addr, wdata: wd};
        @(posedge mclk_in);
        #1;
        req_out = '0;
        rd = rdata_in;
        er = (ack_in === 1'b1) ? err_in : 1'b1;
    endtask
endmodule // host_model
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for reset, sleep and boot control
// Assumes: short boot count, supplies flagged by level
// Notes  : the host model makes every host register access; the bench drives the sequencer port itself
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BOOT = 4;
    logic                     mclk_in  = 1'b0;
    logic                     rst_n_in = 1'b0;
    logic                     pin_n    = 1'b1;
    logic                     core_ok  = 1'b1;
    reset_wake_pkg::reg_req_t host_req;
    reset_wake_pkg::reg_req_t seq_req  = '0;
    reset_wake_pkg::pad_cfg_t pad;
    logic [15:0]              rdata, rd;
    logic [5:0]               fixed_oe;
    logic                     ack, err, er, pu, pd, kp_oe, kp_lvl, core_pu, sleep, flag, ev, gp;
    int                       fail_count = 0;
    int                       compares   = 0;
    int                       cycles     = 0;

    reset_wake_boot_control #(.BOOT_CYCLES(BOOT)) uut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .host_req_in(host_req), .seq_req_in(seq_req),
        .reg_rdata_out(rdata), .reg_ack_out(ack), .reg_err_out(err), .reset_pin_n_in(pin_n),
        .analog_supply_ok_in(1'b1), .io_supply_one_ok_in(1'b1), .core_supply_ok_in(core_ok),
        .reset_pin_pullup_en_out(pu), .reset_pin_pulldown_en_out(pd), .reset_keeper_oe_out(kp_oe),
        .reset_keeper_level_out(kp_lvl), .core_regulator_enable_pin_pu_out(core_pu),
        .pad_cfg_out(pad), .fixed_out_oe_out(fixed_oe), .sleep_out(sleep),
        .boot_complete_flag_out(flag), .boot_event_out(ev), .boot_gpio_out(gp));

    host_model host (.mclk_in(mclk_in), .flag_in(flag), .ack_in(ack), .err_in(err),
                     .rdata_in(rdata), .req_out(host_req));

    always #5 mclk_in = ~mclk_in;

    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // shared checking tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rw(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic early,
                      input logic e_err, input logic [15:0] e_rd);
        host.access(wr, a, d, early, rd, er);
        check({15'h0, er}, {15'h0, e_err});
        if (!wr)
            check(rd, e_rd);
    endtask

    // waits for boot completion and sees the event pulse on the way
    task automatic wait_boot;
        int   n;
        logic seen_ev;
        n = 0;
        seen_ev = 1'b0;
        while (flag !== 1'b1 && n < 200)
        begin
            @(posedge mclk_in);
            #1;
            seen_ev = seen_ev | (ev === 1'b1);
            n++;
        end
        check({15'h0, seen_ev}, 16'h1);
        check({15'h0, gp}, 16'h1);
        check({15'h0, flag}, 16'h1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        repeat (20) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        check({15'h0, flag}, 16'h0);
        // the short boot ends five edges after release: refusal and busy status must come first
        rw(1'b1, reset_wake_pkg::ADDR_MISC_PAD, 16'h0003, 1'b1, 1'b1, 16'h0);
        rw(1'b0, reset_wake_pkg::ADDR_RAW_STATUS5, 16'h0, 1'b1, 1'b0, 16'h0000);
        wait_boot();
        rw(1'b0, reset_wake_pkg::ADDR_MISC_PAD, 16'h0, 1'b1, 1'b0, reset_wake_pkg::MISC_PAD_RESET);
        rw(1'b0, reset_wake_pkg::ADDR_PIN_FUNC, 16'h0, 1'b1, 1'b0, reset_wake_pkg::PIN_FUNC_RESET);
        check(pad, reset_wake_pkg::PIN_FUNC_RESET);
        check({14'h0, pu, pd}, 16'h0002);
        check({10'h0, fixed_oe}, 16'h003F);
        rw(1'b0, reset_wake_pkg::ADDR_RAW_STATUS5, 16'h0, 1'b0, 1'b0, 16'h0100);
        rw(1'b0, reset_wake_pkg::ADDR_RESET_ID, 16'h0, 1'b0, 1'b0, reset_wake_pkg::DEVICE_ID_VALUE);
    endtask

    task automatic t_keeper;
        rw(1'b1, reset_wake_pkg::ADDR_MISC_PAD, 16'h4003, 1'b0, 1'b0, 16'h0);
        check({12'h0, core_pu, kp_oe, pu, pd}, 16'h000F);
        check({15'h0, kp_lvl}, 16'h0001);
        rw(1'b1, reset_wake_pkg::ADDR_RAW_STATUS5, 16'h0000, 1'b0, 1'b1, 16'h0);
        rw(1'b0, 16'h0211, 16'h0, 1'b0, 1'b1, 16'h0);
        // first init pair: its target is outside this block, so it is refused as unmapped
        rw(1'b1, 16'h0211, 16'h0014, 1'b0, 1'b1, 16'h0);
        rw(1'b1, reset_wake_pkg::ADDR_WSEQ_BASE, 16'hA5A5, 1'b0, 1'b0, 16'h0);
    endtask

    task automatic t_resets;
        for (int k = 0; k < 2; k++)
        begin
            rw(1'b1, reset_wake_pkg::ADDR_MISC_PAD, 16'h0003, 1'b0, 1'b0, 16'h0);
            // no audio bus link runs and the core supply is external: nothing precedes the reset
            if (k == 0)
                rw(1'b1, reset_wake_pkg::ADDR_RESET_ID, 16'h5A5A, 1'b0, 1'b0, 16'h0);
            else
                pin_n = 1'b0;
            repeat ((k == 0) ? 2 : 5) @(posedge mclk_in);
            #1;
            check({15'h0, flag}, 16'h0);
            pin_n = 1'b1;
            // boot-time sequencer override of the pin defaults, during the pin-reset boot only
            seq_req.wr    = (k == 1);
            seq_req.addr  = reset_wake_pkg::ADDR_PIN_FUNC;
            seq_req.wdata = 16'h00A5;
            wait_boot();
            seq_req.wr = 1'b0;
            rw(1'b0, reset_wake_pkg::ADDR_MISC_PAD, 16'h0, 1'b0, 1'b0, reset_wake_pkg::MISC_PAD_RESET);
            rw(1'b0, reset_wake_pkg::ADDR_WSEQ_BASE, 16'h0, 1'b0, 1'b0, 16'hA5A5);
            rw(1'b0, reset_wake_pkg::ADDR_PIN_FUNC, 16'h0, 1'b0, 1'b0,
               (k == 1) ? 16'h00A5 : reset_wake_pkg::PIN_FUNC_RESET);
        end
    endtask

    task automatic t_sleep;
        rw(1'b1, reset_wake_pkg::ADDR_PIN_FUNC, 16'hFFFF, 1'b0, 1'b0, 16'h0);
        rw(1'b1, reset_wake_pkg::ADDR_MISC_PAD, 16'h0003, 1'b0, 1'b0, 16'h0);
        core_ok = 1'b0;
        repeat (4) @(posedge mclk_in);
        #1;
        check({15'h0, sleep}, 16'h1);
        check({15'h0, flag}, 16'h0);
        core_ok = 1'b1;
        wait_boot();
        rw(1'b0, reset_wake_pkg::ADDR_PIN_FUNC, 16'h0, 1'b0, 1'b0, (16'hFFFF & reset_wake_pkg::PIN_FUNC_AON)
           | (reset_wake_pkg::PIN_FUNC_RESET & ~reset_wake_pkg::PIN_FUNC_AON));
        rw(1'b0, reset_wake_pkg::ADDR_MISC_PAD, 16'h0, 1'b0, 1'b0, 16'h0003);
        rw(1'b0, reset_wake_pkg::ADDR_WSEQ_BASE, 16'h0, 1'b0, 1'b0, 16'hA5A5);
    endtask

    initial
    begin
        t_defaults();
        t_keeper();
        t_resets();
        t_sleep();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
